//--- include/ealc_pkg.sv
// Package for the E1/T1 alarm supervision and loopback controller
`default_nettype none
package ealc_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned SLICE_S         = 1;
  localparam int unsigned SLICE_CYCLES    = CLK_HZ * SLICE_S;
  localparam int unsigned LOF_HOLD_S      = 10;
  localparam int unsigned BER_HOLD_S      = 11;
  localparam int unsigned BER_WINDOW      = 10;
  localparam int unsigned BER_DIVISOR     = 1000;
  localparam int unsigned DAY_SLICES      = 86400;
  localparam int unsigned LINE_BIT_HZ     = 5_000_000;
  localparam int unsigned LOS_TIMEOUT_CYC = 64;

  localparam logic [3:0] ADDR_CONFIG  = 4'h0;
  localparam logic [3:0] ADDR_ALARM   = 4'h1;
  localparam logic [3:0] ADDR_EVENT   = 4'h2;
  localparam logic [3:0] ADDR_MASK    = 4'h3;
  localparam logic [3:0] ADDR_STAT_SL = 4'h4;
  localparam logic [3:0] ADDR_STAT_AL = 4'h5;
  localparam logic [3:0] ADDR_BERCNT  = 4'h6;
  localparam logic [3:0] ADDR_PORT    = 4'h7;

  localparam int unsigned ALM_LOS = 0;
  localparam int unsigned ALM_LOF = 1;
  localparam int unsigned ALM_BER = 2;
  localparam int unsigned ALM_RAI = 3;
  localparam int unsigned ALM_AIS = 4;
  localparam int unsigned NUM_ALM = 5;

  localparam int unsigned CFG_E1   = 0;
  localparam int unsigned CFG_ESF  = 1;
  localparam int unsigned CFG_B8ZS = 2;
  localparam int unsigned CFG_INTC = 3;
  localparam logic [2:0]  LOOP_LSB = 3'h4;

  typedef enum logic [2:0] {
    EALC_LB_NONE    = 3'h0,
    EALC_LB_DIAG    = 3'h1,
    EALC_LB_LLINE   = 3'h2,
    EALC_LB_LPAY    = 3'h3,
    EALC_LB_RLINE   = 3'h4,
    EALC_LB_RPAY    = 3'h5
  } ealc_loop_t;

  typedef struct packed {
    logic       e1_mode;
    logic       esf;
    logic       alt_code;
    logic       internal_clk;
    ealc_loop_t loop;
  } ealc_cfg_t;

  localparam ealc_cfg_t CFG_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, EALC_LB_NONE};

  typedef struct packed {
    logic data;
    logic alarm_ais;
    logic req_line_loop;
    logic req_pay_loop;
    logic remote_alarm;
  } ealc_tx_t;

  typedef enum logic [3:0] {
    EALC_ST_NORMAL = 4'b0001,
    EALC_ST_DRAIN  = 4'b0010,
    EALC_ST_LOOP   = 4'b0100,
    EALC_ST_RESV   = 4'b1000
  } ealc_state_t;
endpackage : ealc_pkg
`default_nettype wire

//--- verilog/ealc_top.sv
// E1/T1 alarm supervision and loopback controller
//
// Contract
// R1: Lost receive clock raises LOS, signal light off, alarm light on.
// R2: Lost frame alignment raises LOF and lights the alarm light.
// R3: LOF stays reported ten seconds after its cause clears.
// R4: BER alarm when errors reach one per thousand bits over ten seconds.
// R5: BER alarm stays reported eleven seconds after its cause clears.
// R6: BER alarm shown only in status, never on a light.
// R7: Far-end remote alarm flags major alarm, lights alarm, shows in status.
// R8: Far-end AIS flags major alarm, lights alarm, shows in status.
// R9: Any local alarm sends a remote alarm signal toward the peer.
// R10: Every alarm state change sets an event naming port and cause.
// R11: Twenty-four hour statistics are readable beside the current alarm state.
// R12: Diagnostic loop returns transmit data to processor, sends AIS on line.
// R13: Local line loop sends received line straight back to the peer.
// R14: Local payload loop passes received data, reframes, sends it back.
// R15: T1 remote line loop sends line-loop request code to the peer.
// R16: T1 remote payload loop request, allowed only with ESF framing.
// R17: Reset defaults: T1, SF, AMI, line clocking.
// R18: BER counted in one-second slices over a sliding ten-slice window.
// R19: One loop mode at a time; none restores normal paths within a frame.
//
// The plain strobed port and the placing of the registers were left to the implementer.
`default_nettype none
module ealc_top
  import ealc_pkg::*;
#(
  parameter int unsigned SLICE_LEN = SLICE_CYCLES,
  parameter int unsigned DAY_LEN   = DAY_SLICES,
  parameter int unsigned FRAME_LEN = 193,
  parameter logic [1:0]  PORT_ID   = 2'h1
) (
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  input  wire logic                     line_clk,
  input  wire logic                     rx_data,
  input  wire logic                     rx_frame_lock,
  input  wire logic                     rx_bit_error,
  input  wire logic                     rx_remote_alarm,
  input  wire logic                     rx_ais,
  input  wire logic                     cpu_tx_data,
  input  wire logic                     framer_tx_data,
  input  wire logic [3:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [31:0]              reg_rdata,
  output logic                          irq,
  output logic                          signal_present_light,
  output logic                          alarm_light,
  output ealc_pkg::ealc_tx_t            tx,
  output logic                          cpu_rx_data
);
  import ealc_pkg::*;

  // Counter widths bound the day and frame counts
  if (SLICE_LEN < 2 || DAY_LEN < 2 || DAY_LEN > 32'h20000 || FRAME_LEN < 2 ||
      FRAME_LEN > 32'h10000) begin : g_bad_counts
    $error("ealc_top: counts out of range");
  end

  localparam int unsigned LOS_CYC  = LOS_TIMEOUT_CYC;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [5:0] sync_a;
  logic [5:0] sync_b;
  logic       clk_prev;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync_a   <= 6'h00;
      sync_b   <= 6'h00;
      clk_prev <= 1'b0;
    end else begin
      sync_a   <= {line_clk, rx_data, rx_frame_lock, rx_bit_error, rx_remote_alarm, rx_ais};
      sync_b   <= sync_a;
      clk_prev <= sync_b[5];
    end
  end
  wire logic s_data  = sync_b[4];
  wire logic s_lock  = sync_b[3];
  wire logic s_err   = sync_b[2];
  wire logic s_rai   = sync_b[1];
  wire logic s_ais   = sync_b[0];
  wire logic bit_tick = sync_b[5] & ~clk_prev;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration
  ealc_cfg_t cfg;
  ealc_loop_t next_loop;
  always_comb begin
    next_loop = ealc_loop_t'(reg_wdata[LOOP_LSB +: 3]);
    if ((next_loop == EALC_LB_RLINE || next_loop == EALC_LB_RPAY) && reg_wdata[CFG_E1]) begin
      next_loop = EALC_LB_NONE; // R15
    end
    if (next_loop == EALC_LB_RPAY && !reg_wdata[CFG_ESF]) begin
      next_loop = EALC_LB_NONE; // R16
    end
    if (next_loop > EALC_LB_RPAY) begin
      next_loop = EALC_LB_NONE;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg <= CFG_RESET; // R17
    end else if (reg_wr && reg_addr == ADDR_CONFIG) begin
      cfg.e1_mode      <= reg_wdata[CFG_E1];
      cfg.esf          <= reg_wdata[CFG_ESF];
      cfg.alt_code     <= reg_wdata[CFG_B8ZS];
      cfg.internal_clk <= reg_wdata[CFG_INTC];
      cfg.loop         <= next_loop; // R19
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Loss of signal: no rising line clock edge within a timeout
  logic [7:0] los_cnt;
  logic       los;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      los_cnt <= 8'h00;
      los     <= 1'b1;
    end else if (bit_tick) begin
      los_cnt <= 8'h00;
      los     <= 1'b0;
    end else if (los_cnt == 8'(LOS_CYC - 1)) begin
      los     <= 1'b1; // R1
    end else begin
      los_cnt <= los_cnt + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // One-second slices and holdoff timers
  logic [31:0] slice_cnt;
  logic        slice_tick;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      slice_cnt  <= 32'h0;
      slice_tick <= 1'b0;
    end else begin
      slice_tick <= (slice_cnt == 32'(SLICE_LEN - 1));
      slice_cnt  <= (slice_cnt == 32'(SLICE_LEN - 1)) ? 32'h0 : slice_cnt + 32'h1; // R18
    end
  end

  logic       lof;
  logic [3:0] lof_hold;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lof      <= 1'b0;
      lof_hold <= 4'h0;
    end else if (!s_lock && !los) begin
      lof      <= 1'b1; // R2
      lof_hold <= 4'(LOF_HOLD_S);
    end else if (slice_tick && lof) begin
      if (lof_hold == 4'h0) begin
        lof <= 1'b0;
      end else begin
        lof_hold <= lof_hold - 4'h1; // R3
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bit error rate over a sliding window of slices
  logic [31:0] slice_err;
  logic [31:0] slice_bits;
  logic [31:0] win_err [BER_WINDOW];
  logic [31:0] win_bits [BER_WINDOW];
  logic [31:0] sum_err;
  logic [31:0] sum_bits;
  logic        ber_cause;
  always_comb begin
    sum_err  = 32'h0;
    sum_bits = 32'h0;
    for (int i = 0; i < BER_WINDOW; i++) begin
      sum_err  = sum_err + win_err[i];
      sum_bits = sum_bits + win_bits[i];
    end
    ber_cause = (sum_bits != 32'h0) &&
                (64'(sum_err) * 64'(BER_DIVISOR) >= 64'(sum_bits)); // R4
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      slice_err  <= 32'h0;
      slice_bits <= 32'h0;
      for (int i = 0; i < BER_WINDOW; i++) begin
        win_err[i]  <= 32'h0;
        win_bits[i] <= 32'h0;
      end
    end else if (slice_tick) begin
      win_err[0]  <= slice_err;
      win_bits[0] <= slice_bits;
      for (int i = 1; i < BER_WINDOW; i++) begin
        win_err[i]  <= win_err[i-1]; // R18
        win_bits[i] <= win_bits[i-1];
      end
      slice_err  <= 32'h0;
      slice_bits <= 32'h0;
    end else if (bit_tick) begin
      slice_bits <= slice_bits + 32'h1;
      slice_err  <= slice_err + {31'h0, s_err};
    end
  end

  logic       ber;
  logic [3:0] ber_hold;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ber      <= 1'b0;
      ber_hold <= 4'h0;
    end else if (slice_tick) begin
      if (ber_cause) begin
        ber      <= 1'b1;
        ber_hold <= 4'(BER_HOLD_S);
      end else if (ber) begin
        if (ber_hold == 4'h0) begin
          ber <= 1'b0;
        end else begin
          ber_hold <= ber_hold - 4'h1; // R5
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Alarm vector, lights and events
  logic [NUM_ALM-1:0] alarms;
  logic [NUM_ALM-1:0] alarms_prev;
  logic [NUM_ALM-1:0] event_st;
  logic [NUM_ALM-1:0] mask;
  logic [2:0]         last_cause;
  wire logic [NUM_ALM-1:0] changes = alarms ^ alarms_prev;
  assign alarms = {s_ais, s_rai, ber, lof, los}; // R7 R8
  wire logic rd_event = reg_rd && reg_addr == ADDR_EVENT;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      alarms_prev <= '0;
      event_st    <= '0;
      last_cause  <= 3'h0;
    end else begin
      alarms_prev <= alarms;
      event_st    <= (rd_event ? '0 : event_st) | changes; // R10
      for (int i = 0; i < NUM_ALM; i++) begin
        if (changes[i]) begin
          last_cause <= 3'(i);
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mask <= '0;
    end else if (reg_wr && reg_addr == ADDR_MASK) begin
      mask <= reg_wdata[NUM_ALM-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      signal_present_light <= 1'b0;
      alarm_light          <= 1'b0;
      irq                  <= 1'b0;
    end else begin
      signal_present_light <= ~los; // R1
      alarm_light <= los | lof | s_rai | s_ais; // R2 R6 R7 R8
      irq <= |(event_st & mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Day statistics: alarmed slices over each completed 24-hour period
  logic [16:0] day_cnt;
  logic [16:0] sec_total;
  logic [16:0] sec_alarm;
  logic [16:0] stat_total;
  logic [16:0] stat_alarm;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      day_cnt    <= 17'h0;
      sec_total  <= 17'h0;
      sec_alarm  <= 17'h0;
      stat_total <= 17'h0;
      stat_alarm <= 17'h0;
    end else if (slice_tick) begin
      if (day_cnt == 17'(DAY_LEN - 1)) begin
        day_cnt    <= 17'h0;
        stat_total <= sec_total + 17'h1; // R11
        stat_alarm <= sec_alarm + {16'h0, |alarms};
        sec_total  <= 17'h0;
        sec_alarm  <= 17'h0;
      end else begin
        day_cnt   <= day_cnt + 17'h1;
        sec_total <= sec_total + 17'h1;
        sec_alarm <= sec_alarm + {16'h0, |alarms};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Loopback path and transmit side
  ealc_state_t lb_state;
  logic [15:0] frame_cnt;
  ealc_loop_t  active_loop;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lb_state    <= EALC_ST_NORMAL;
      frame_cnt   <= 16'h0;
      active_loop <= EALC_LB_NONE;
    end else begin
      case (lb_state)
        EALC_ST_NORMAL: begin
          if (cfg.loop != EALC_LB_NONE) begin
            active_loop <= cfg.loop;
            lb_state    <= EALC_ST_LOOP;
          end
        end
        EALC_ST_LOOP: begin
          if (cfg.loop != active_loop) begin
            active_loop <= EALC_LB_NONE; // R19
            frame_cnt   <= 16'h0;
            lb_state    <= EALC_ST_DRAIN;
          end
        end
        EALC_ST_DRAIN: begin
          if (bit_tick) begin
            frame_cnt <= frame_cnt + 16'h1;
          end
          if (frame_cnt == 16'(FRAME_LEN - 1) || los) begin
            lb_state <= EALC_ST_NORMAL; // R19
          end
        end
        default: begin
          lb_state <= EALC_ST_NORMAL;
        end
      endcase
    end
  end

  wire logic local_alarm = los | lof | ber;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tx          <= '0;
      cpu_rx_data <= 1'b0;
    end else begin
      tx.remote_alarm  <= local_alarm; // R9
      tx.alarm_ais     <= (active_loop == EALC_LB_DIAG); // R12
      tx.req_line_loop <= (active_loop == EALC_LB_RLINE) && !cfg.e1_mode; // R15
      tx.req_pay_loop  <= (active_loop == EALC_LB_RPAY) && !cfg.e1_mode && cfg.esf; // R16
      case (active_loop)
        EALC_LB_DIAG: begin
          tx.data     <= 1'b1; // R12
          cpu_rx_data <= cpu_tx_data;
        end
        EALC_LB_LLINE: begin
          tx.data     <= s_data; // R13
          cpu_rx_data <= s_data;
        end
        EALC_LB_LPAY: begin
          tx.data     <= framer_tx_data; // R14
          cpu_rx_data <= s_data;
        end
        default: begin
          tx.data     <= cpu_tx_data;
          cpu_rx_data <= s_data;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read port
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_CONFIG:  reg_rdata <= {25'h0, cfg.loop, cfg.internal_clk, cfg.alt_code,
                                    cfg.esf, cfg.e1_mode};
        ADDR_ALARM:   reg_rdata <= {27'h0, alarms}; // R6 R7 R8 R11
        ADDR_EVENT:   reg_rdata <= {24'h0, last_cause, event_st};
        ADDR_MASK:    reg_rdata <= {27'h0, mask};
        ADDR_STAT_SL: reg_rdata <= {15'h0, stat_total};
        ADDR_STAT_AL: reg_rdata <= {15'h0, stat_alarm};
        ADDR_BERCNT:  reg_rdata <= sum_err;
        ADDR_PORT:    reg_rdata <= {30'h0, PORT_ID}; // R10
        default:      reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end
endmodule : ealc_top
`default_nettype wire

//--- verif/ealc_props.sv
// Port checks for the alarm supervision and loopback controller
`default_nettype none
module ealc_props
  import ealc_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              reset,
  input wire logic              line_clk,
  input wire logic              rx_frame_lock,
  input wire logic              rx_remote_alarm,
  input wire logic              rx_ais,
  input wire logic [3:0]        reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  input wire logic              signal_present_light,
  input wire logic              alarm_light,
  input wire ealc_pkg::ealc_tx_t tx
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  logic [7:0] still_cnt;
  logic       line_q;
  logic       cfg_wr;

  // Cycles since the line clock last moved
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      line_q    <= 1'h0;
      still_cnt <= 8'h00;
    end else begin
      line_q <= line_clk;
      if (line_clk != line_q) begin
        still_cnt <= 8'h00;
      end else if (still_cnt != 8'hFF) begin
        still_cnt <= still_cnt + 8'h01;
      end
    end
  end

  assign cfg_wr = reg_wr && (reg_addr == ADDR_CONFIG);

  ////////////////////////////////////////////////////////////////////////////
  chk_los_lights: assert property (!signal_present_light && !$past(reset) |-> alarm_light)
    else $error("signal light off without alarm light");
  chk_los_timeout: assert property (still_cnt == 8'h50 |-> !signal_present_light)
    else $error("stopped line clock not flagged");
  chk_rai_light: assert property ($rose(rx_remote_alarm) |-> ##[1:8] alarm_light)
    else $error("remote alarm not lit");
  chk_ais_light: assert property ($rose(rx_ais) |-> ##[1:8] alarm_light)
    else $error("blue alarm not lit");
  chk_lof_remote: assert property ($fell(rx_frame_lock) && signal_present_light
    |-> ##[1:8] (alarm_light && tx.remote_alarm)) else $error("frame loss not reported");
  chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  chk_diag_ais: assert property (cfg_wr && reg_wdata[6:4] == 3'h1
    |-> ##[1:6] (tx.alarm_ais && tx.data)) else $error("diag loop without blue");
  chk_rline_e1: assert property (cfg_wr && reg_wdata[6:4] == 3'h4 && reg_wdata[0]
    |-> ##6 (!tx.req_line_loop) [*4]) else $error("line loop request in E1");
  chk_rpay_sf: assert property (cfg_wr && reg_wdata[6:4] == 3'h5 && !reg_wdata[1]
    |-> ##6 (!tx.req_pay_loop) [*4]) else $error("payload request without ESF");
  chk_one_loop: assert property (!(tx.req_line_loop && tx.req_pay_loop))
    else $error("two loop requests at once");
  chk_none_clears: assert property (cfg_wr && reg_wdata[6:4] == 3'h0
    |-> ##[1:6] !(tx.alarm_ais || tx.req_line_loop || tx.req_pay_loop))
    else $error("loop not left");
endmodule : ealc_props

bind ealc_top ealc_props u_props (
  .core_clk(core_clk), .reset(reset), .line_clk(line_clk),
  .rx_frame_lock(rx_frame_lock), .rx_remote_alarm(rx_remote_alarm), .rx_ais(rx_ais),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .signal_present_light(signal_present_light),
  .alarm_light(alarm_light), .tx(tx)
);
`default_nettype wire

//--- verif/ealc_peer.sv
// Far-end line peer model
`default_nettype none
module ealc_peer
  import ealc_pkg::*;
(
  input wire logic               run,
  input wire logic               lock,
  input wire logic               err,
  input wire logic               rai,
  input wire logic               ais,
  input wire logic               din,
  input wire ealc_pkg::ealc_tx_t tx,
  output logic                   line_clk,
  output logic                   rx_data,
  output logic                   rx_frame_lock,
  output logic                   rx_bit_error,
  output logic                   rx_remote_alarm,
  output logic                   rx_ais
);
  timeunit 1ns;
  timeprecision 1ps;

  // Clock stands still while the line is idle
  initial begin
    line_clk     = 1'h0;
    rx_data      = 1'h0;
    rx_bit_error = 1'h0;
    #37;
    forever begin
      #100;
      line_clk = run ? ~line_clk : 1'h0;
    end
  end

  always @(negedge line_clk) begin
    rx_data      <= (tx.req_line_loop || tx.req_pay_loop) ? tx.data : din;
    rx_bit_error <= err;
  end

  assign rx_frame_lock   = lock;
  assign rx_remote_alarm = rai;
  assign rx_ais          = ais;
endmodule : ealc_peer
`default_nettype wire

//--- verif/tb_ealc_top.sv
// Self-checking testbench for the alarm supervision and loopback controller
`default_nettype none
module tb_ealc_top
  import ealc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk = 1'h0;
  logic        reset = 1'h1;
  logic        run = 1'h0, lock = 1'h1, err = 1'h0, rai = 1'h0, ais = 1'h0, din = 1'h0;
  logic        cpu_tx_data = 1'h0, framer_tx_data = 1'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'h0, reg_rd = 1'h0, rd_seen = 1'h0;
  logic        line_clk, rx_data, rx_frame_lock, rx_bit_error, rx_remote_alarm, rx_ais;
  logic [31:0] reg_rdata, m;
  logic        irq, signal_present_light, alarm_light, cpu_rx_data;
  ealc_tx_t    tx;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  int          bad_count = 0, checks_done = 0, cycles = 0;

  always #12.5 core_clk = ~core_clk;

  ealc_top #(.SLICE_LEN(100), .DAY_LEN(20), .FRAME_LEN(8)) dut (
    .core_clk(core_clk), .reset(reset), .line_clk(line_clk), .rx_data(rx_data),
    .rx_frame_lock(rx_frame_lock), .rx_bit_error(rx_bit_error),
    .rx_remote_alarm(rx_remote_alarm), .rx_ais(rx_ais), .cpu_tx_data(cpu_tx_data),
    .framer_tx_data(framer_tx_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .signal_present_light(signal_present_light), .alarm_light(alarm_light), .tx(tx),
    .cpu_rx_data(cpu_rx_data)
  );

  ealc_peer peer (
    .run(run), .lock(lock), .err(err), .rai(rai), .ais(ais), .din(din), .tx(tx),
    .line_clk(line_clk), .rx_data(rx_data), .rx_frame_lock(rx_frame_lock),
    .rx_bit_error(rx_bit_error), .rx_remote_alarm(rx_remote_alarm), .rx_ais(rx_ais)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic chk1(input logic seen, input logic want);
    chk({31'h0, seen}, {31'h0, want});
  endtask : chk1

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
    @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic [31:0] k);
    exp_q.push_back({x & k, k});
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    @(posedge core_clk);
  endtask : rd

  task automatic lp(input logic [31:0] w, input logic [31:0] rb, input logic [4:0] te,
                    input logic [4:0] tm);
    logic [4:0] tv;
    wr(ADDR_CONFIG, 32'h0);
    tick(80);
    wr(ADDR_CONFIG, w);
    rd(ADDR_CONFIG, rb, 32'h7F);
    tick(40);
    @(negedge core_clk);
    tv = tx;
    chk({27'h0, tv & tm}, {27'h0, te & tm});
    @(posedge core_clk);
  endtask : lp

  task automatic test_done;
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // Read results stand in the cycle after the strobe
  always @(negedge core_clk) begin
    if (rd_seen) begin
      e = exp_q.pop_front();
      chk(reg_rdata & e[31:0], e[63:32]);
    end
    rd_seen <= reg_rd;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hFDFB5289));
    tick(8);
    reset <= 1'h0;
    tick(1);
    rd(ADDR_CONFIG, 32'h0, 32'h7F);
    rd(4'hC, 32'h0, 32'hFFFFFFFF);
    rd(ADDR_ALARM, 32'h1, 32'h1F);
    @(negedge core_clk);
    chk1(signal_present_light, 1'h0);
    chk1(alarm_light, 1'h1);
    @(posedge core_clk);
    run <= 1'h1;
    tick(100);
    rd(ADDR_ALARM, 32'h0, 32'h1F);
    rd(ADDR_EVENT, 32'h1, 32'h1);
    rd(ADDR_EVENT, 32'h0, 32'h1F);
    m = $urandom();
    wr(ADDR_MASK, m);
    rd(ADDR_MASK, m, 32'h1F);
    wr(ADDR_MASK, 32'h8);
    rai <= 1'h1;
    tick(10);
    @(negedge core_clk);
    chk1(irq, 1'h1);
    chk1(alarm_light, 1'h1);
    @(posedge core_clk);
    rd(ADDR_ALARM, 32'h8, 32'h1F);
    rd(ADDR_EVENT, 32'h68, 32'hFF);
    @(negedge core_clk);
    chk1(irq, 1'h0);
    @(posedge core_clk);
    wr(ADDR_MASK, 32'h0);
    rai <= 1'h0;
    ais <= 1'h1;
    tick(10);
    @(negedge core_clk);
    chk1(irq, 1'h0);
    chk1(alarm_light, 1'h1);
    @(posedge core_clk);
    rd(ADDR_ALARM, 32'h10, 32'h1F);
    rd(ADDR_EVENT, 32'h18, 32'h1F);
    ais <= 1'h0;
    lock <= 1'h0;
    tick(10);
    rd(ADDR_ALARM, 32'h2, 32'h1F);
    @(negedge core_clk);
    chk1(alarm_light, 1'h1);
    chk1(tx.remote_alarm, 1'h1);
    @(posedge core_clk);
    lock <= 1'h1;
    tick(800);
    rd(ADDR_ALARM, 32'h2, 32'h1F);
    tick(400);
    rd(ADDR_ALARM, 32'h0, 32'h1F);
    run <= 1'h0;
    tick(90);
    rd(ADDR_ALARM, 32'h1, 32'h1F);
    run <= 1'h1;
    tick(100);
    err <= 1'h1;
    tick(250);
    rd(ADDR_ALARM, 32'h4, 32'h1F);
    @(negedge core_clk);
    chk1(alarm_light, 1'h0);
    chk1(tx.remote_alarm, 1'h1);
    @(posedge core_clk);
    err <= 1'h0;
    tick(1500);
    rd(ADDR_ALARM, 32'h4, 32'h1F);
    tick(1200);
    rd(ADDR_ALARM, 32'h0, 32'h1F);
    rd(ADDR_BERCNT, 32'h0, 32'hFFFFFFFF);
    rd(ADDR_STAT_SL, 32'h14, 32'h1FFFF);
    rd(ADDR_PORT, 32'h1, 32'h3);
    m = $urandom();
    din <= m[0];
    cpu_tx_data <= m[0];
    framer_tx_data <= ~m[0];
    lp(32'h10, 32'h10, 5'h18, 5'h1E);
    @(negedge core_clk);
    chk1(cpu_rx_data, m[0]);
    @(posedge core_clk);
    lp(32'h20, 32'h20, {m[0], 4'h0}, 5'h1E);
    lp(32'h30, 32'h30, {~m[0], 4'h0}, 5'h1E);
    lp(32'h40, 32'h40, 5'h04, 5'h0E);
    lp(32'h41, 32'h01, 5'h00, 5'h0E);
    lp(32'h52, 32'h52, 5'h02, 5'h0E);
    lp(32'h50, 32'h00, 5'h00, 5'h0E);
    lp(32'h00, 32'h00, 5'h00, 5'h0E);
    tick(2);
    test_done();
  end
endmodule : tb_ealc_top
`default_nettype wire
